// ==== core/abu_map.vh ====
`ifndef ABU_MAP_VH
`define ABU_MAP_VH
// Printed register offsets (byte addresses on the bus)
`define ABU_OFF_BRK_HIGH 16'hfe0c
`define ABU_OFF_BRK_LOW 16'hfe0d
`define ABU_OFF_STATUS_CTRL 16'hfe0e
// Own registers, word aligned
`define ABU_OFF_FLAG_CTRL 16'hfe10
`define ABU_OFF_IRQ_STATUS 16'hfe14
`define ABU_OFF_IRQ_MASK 16'hfe18
`define ABU_OFF_SYS_STATUS 16'hfe1c
// Field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_CLEAR_EN 7
`define ABU_BIT_WAIT_EXIT 0
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_SOFT 1
`define ABU_IRQ_WAIT 2
// Reset values
`define ABU_RST_BYTE 8'h00
`define ABU_RST_WORD 32'h0000_0000
// Bus responses
`define ABU_RESP_OKAY 2'b00
`define ABU_RESP_SLVERR 2'b10
`endif

// ==== core/abu_match.v ====
`default_nettype none
// Compares program-counter addresses against the break address
module abu_match #(
  parameter AW = 16
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire [AW-1:0] addr_i,
  input wire addr_from_pc_i,
  input wire [AW-1:0] break_addr_i,
  input wire enable_i,
  input wire stop_mode_i,
  output reg hit_o
);
  // Registered hit: one cycle latency, no combinational path into the core
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= enable_i & addr_from_pc_i & ~stop_mode_i & (addr_i == break_addr_i);
    end
  end
endmodule
`default_nettype wire

// ==== core/abu_top.v ====
`include "abu_map.vh"
`default_nettype none
// Overview of operation
// - Request break when address equals break address
// - Only program counter addresses may match
// - Enable flag gates address-match breaks
// - Active flag set by hardware on match
// - Writing one to active flag requests break
// - Two byte break address registers, reset zero
// - Status/control register decoded at its address
// - Clear enable permits peripheral flag clears
// - Hold timer counter stopped during break
// - Disable watchdog in break with high voltage
// - Active in wait; record wait exit by break
// - Inactive in stop; registers kept
module abu_top #(
  parameter AW = 16
) (
  input wire sys_clk_i,
  input wire rstn_i,
  // AXI4-Lite slave
  input wire [15:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [15:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Core side
  input wire [AW-1:0] cpu_addr_i,
  input wire cpu_addr_from_pc_i,
  input wire cpu_rti_i,
  input wire wait_mode_i,
  input wire stop_mode_i,
  input wire high_test_voltage_i,
  output wire break_req_o,
  output wire break_in_progress_o,
  output wire timer_stop_o,
  output wire watchdog_disable_o,
  output wire flag_clear_allow_o,
  output wire irq_o
);
  reg [7:0] break_addr_high;
  reg [7:0] break_addr_low;
  reg break_enable_flag;
  reg break_active_flag;
  reg break_flag_clear_enable;
  reg break_wait_status;
  reg in_break;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [15:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire match_hit;
  wire wr_fire;
  wire wr_status;
  wire soft_break;
  wire [2:0] irq_events;
  wire [15:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [8:0] status_lane;

  // Word-aligned byte lane of a byte address
  function [1:0] lane;
    input [15:0] a;
    begin
      lane = a[1:0];
    end
  endfunction

  // Byte from the selected lane, or no write when its strobe is clear
  function [8:0] lane_byte;
    input [31:0] d;
    input [3:0] s;
    input [1:0] l;
    begin
      lane_byte = {s[l], d[8*l +: 8]};
    end
  endfunction

  abu_match #(.AW(AW)) u_match (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .addr_i(cpu_addr_i),
    .addr_from_pc_i(cpu_addr_from_pc_i),
    .break_addr_i({break_addr_high, break_addr_low}),
    .enable_i(break_enable_flag),
    .stop_mode_i(stop_mode_i),
    .hit_o(match_hit)
  );

  // Write channel: address and data accepted in either order
  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held & ~s_axi_bvalid_o;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wr_data = w_held ? w_data : s_axi_wdata_i;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  assign wr_fire = (aw_held | s_axi_awvalid_i) & (w_held | s_axi_wvalid_i) & ~s_axi_bvalid_o;
  // Printed offsets share one word; each sits in its own byte lane
  // Only the lane strobe qualifies; the data byte itself may be zero
  assign status_lane = lane_byte(wr_data, wr_strb, lane(`ABU_OFF_STATUS_CTRL));
  assign wr_status = wr_fire && ({wr_addr[15:2], 2'b00} == {`ABU_OFF_STATUS_CTRL >> 2, 2'b00}) &&
    status_lane[8];
  assign soft_break = wr_status & wr_data[8*lane(`ABU_OFF_STATUS_CTRL) + `ABU_BIT_ACTIVE];

  // Hold halves until the pair is complete
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= `ABU_RST_WORD;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `ABU_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= ((wr_addr[15:2] == (`ABU_OFF_STATUS_CTRL >> 2)) ||
          (wr_addr == `ABU_OFF_FLAG_CTRL) || (wr_addr == `ABU_OFF_IRQ_STATUS) ||
          (wr_addr == `ABU_OFF_IRQ_MASK)) ? `ABU_RESP_OKAY : `ABU_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_i;
          w_strb <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end
    end
  end

  // Register file; stop mode only freezes matching and break requests, never the contents
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      break_addr_high <= `ABU_RST_BYTE;
      break_addr_low <= `ABU_RST_BYTE;
      break_enable_flag <= 1'b0;
      break_flag_clear_enable <= 1'b0;
      irq_mask <= 3'h0;
    end else if (wr_fire) begin
      if (wr_addr[15:2] == (`ABU_OFF_STATUS_CTRL >> 2)) begin
        if (wr_strb[lane(`ABU_OFF_BRK_HIGH)]) begin
          break_addr_high <= wr_data[8*lane(`ABU_OFF_BRK_HIGH) +: 8];
        end
        if (wr_strb[lane(`ABU_OFF_BRK_LOW)]) begin
          break_addr_low <= wr_data[8*lane(`ABU_OFF_BRK_LOW) +: 8];
        end
        if (wr_status) begin
          break_enable_flag <= wr_data[8*lane(`ABU_OFF_STATUS_CTRL) + `ABU_BIT_ENABLE];
        end
      end
      if (wr_addr == `ABU_OFF_FLAG_CTRL && wr_strb[0]) begin
        break_flag_clear_enable <= wr_data[`ABU_BIT_CLEAR_EN];
      end
      if (wr_addr == `ABU_OFF_IRQ_MASK && wr_strb[0]) begin
        irq_mask <= wr_data[2:0];
      end
    end
  end

  // Active flag: hardware set beats a software clear in the same cycle
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      break_active_flag <= 1'b0;
    end else if (match_hit || soft_break) begin
      break_active_flag <= 1'b1;
    end else if (wr_status) begin
      break_active_flag <= 1'b0;
    end
  end

  // Break state lasts from request until the core returns from interrupt
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_break <= 1'b0;
      break_wait_status <= 1'b0;
    end else begin
      if (break_req_o) begin
        in_break <= 1'b1;
      end else if (cpu_rti_i) begin
        in_break <= 1'b0;
      end
      // Wait exit by break is recorded; cleared when the next wait begins
      if (break_req_o && wait_mode_i) begin
        break_wait_status <= 1'b1;
      end else if (wait_mode_i) begin
        break_wait_status <= 1'b0;
      end
    end
  end

  // Request raised while the active flag stands outside break and stop; core finishes its instruction
  assign break_req_o = break_active_flag & ~in_break & ~stop_mode_i;
  assign break_in_progress_o = in_break;
  assign timer_stop_o = in_break;
  assign watchdog_disable_o = in_break & high_test_voltage_i;
  assign flag_clear_allow_o = ~in_break | break_flag_clear_enable;

  // Sticky interrupt status, write one to clear, set wins
  assign irq_events = {break_req_o & wait_mode_i, soft_break, match_hit};
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= irq_events |
        (irq_status & ~((wr_fire && wr_addr == `ABU_OFF_IRQ_STATUS && wr_strb[0]) ?
        wr_data[2:0] : 3'h0));
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  // Read channel: one cycle after the address is taken
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= `ABU_RST_WORD;
      s_axi_rresp_o <= `ABU_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `ABU_RESP_OKAY;
      case (s_axi_araddr_i[15:2])
        (`ABU_OFF_STATUS_CTRL >> 2): begin
          s_axi_rdata_o <= {8'h00, break_enable_flag, break_active_flag, 6'h00,
            break_addr_low, break_addr_high};
        end
        (`ABU_OFF_FLAG_CTRL >> 2): begin
          s_axi_rdata_o <= {24'h00_0000, break_flag_clear_enable, 7'h00};
        end
        (`ABU_OFF_IRQ_STATUS >> 2): begin
          s_axi_rdata_o <= {29'h0000_0000, irq_status};
        end
        (`ABU_OFF_IRQ_MASK >> 2): begin
          s_axi_rdata_o <= {29'h0000_0000, irq_mask};
        end
        (`ABU_OFF_SYS_STATUS >> 2): begin
          s_axi_rdata_o <= {30'h0000_0000, in_break, break_wait_status};
        end
        default: begin
          s_axi_rdata_o <= `ABU_RST_WORD;
          s_axi_rresp_o <= `ABU_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/abu_monitor.sv ====
`default_nettype none
module abu_monitor (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_wvalid_i,
  input wire logic cpu_addr_from_pc_i,
  input wire logic cpu_rti_i,
  input wire logic stop_mode_i,
  input wire logic high_test_voltage_i,
  input wire logic break_req_o,
  input wire logic break_in_progress_o,
  input wire logic timer_stop_o,
  input wire logic watchdog_disable_o,
  input wire logic flag_clear_allow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // A quiet cycle: no fetch, no bus write, no pending request
  sequence s_idle;
    !break_req_o && !break_in_progress_o && !s_axi_wvalid_i && !s_axi_awvalid_i
      && !cpu_addr_from_pc_i && !stop_mode_i;
  endsequence
  property p_pc_only; s_idle [*3] |=> !break_req_o; endproperty
  property p_req_enters; break_req_o |=> break_in_progress_o; endproperty
  property p_cause; $rose(break_in_progress_o) |-> $past(break_req_o); endproperty
  property p_rti; cpu_rti_i && break_in_progress_o |=> !break_in_progress_o; endproperty
  property p_timer; timer_stop_o == break_in_progress_o; endproperty
  property p_wdog;
    watchdog_disable_o == (break_in_progress_o && high_test_voltage_i);
  endproperty
  property p_clear; !break_in_progress_o |-> flag_clear_allow_o; endproperty
  property p_stop; stop_mode_i |-> !break_req_o; endproperty
  a_pc_only: assert property (p_pc_only) else $error("request without cause");
  a_req_enters: assert property (p_req_enters) else $error("break not entered");
  a_cause: assert property (p_cause) else $error("break without request");
  a_rti: assert property (p_rti) else $error("break not ended");
  a_timer: assert property (p_timer) else $error("timer not held");
  a_wdog: assert property (p_wdog) else $error("watchdog gate wrong");
  a_clear: assert property (p_clear) else $error("flag clear blocked");
  a_stop: assert property (p_stop) else $error("request in stop");
endmodule
bind abu_top abu_monitor u_mon (.sys_clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_wvalid_i,
  .cpu_addr_from_pc_i, .cpu_rti_i, .stop_mode_i, .high_test_voltage_i, .break_req_o,
  .break_in_progress_o, .timer_stop_o, .watchdog_disable_o, .flag_clear_allow_o);
`default_nettype wire

// ==== tb/abu_core_model.sv ====
`default_nettype none
module abu_core_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic fetch_pc_i,
  input wire logic in_break_i,
  output logic [15:0] cpu_addr_o,
  output logic cpu_addr_from_pc_o,
  output var logic cpu_rti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  // In break the core fetches the vector at once, else follows the bench
  assign cpu_addr_o = in_break_i ? 16'hfffc : fetch_addr_i;
  assign cpu_addr_from_pc_o = in_break_i | fetch_pc_i;
  // Fixed routine length so software has time to clear the active flag
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 5'h0;
      cpu_rti_o <= 1'h0;
    end else begin
      cnt <= (in_break_i && !cpu_rti_o) ? cnt + 5'h1 : 5'h0;
      cpu_rti_o <= in_break_i && cnt == 5'h14;
    end
  end
endmodule
`default_nettype wire

// ==== tb/abu_top_test.sv ====
`default_nettype none
module abu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, awv, wv, arv, stop, hv, fpc, awr, wr_, bv, arr, rv, pc, return_from_interrupt;
  logic req, inb, tst, wdd, fca, irq, wm;
  logic [15:0] awa, ara, fa, ca;
  logic [31:0] wd, rdat, q;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, resp;
  int fail_count, comparisons, n;
  abu_top u_dut (.sys_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'h1),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'h1),
    .cpu_addr_i(ca), .cpu_addr_from_pc_i(pc), .cpu_rti_i(return_from_interrupt), .wait_mode_i(wm && !inb),
    .stop_mode_i(stop), .high_test_voltage_i(hv), .break_req_o(req),
    .break_in_progress_o(inb), .timer_stop_o(tst), .watchdog_disable_o(wdd),
    .flag_clear_allow_o(fca), .irq_o(irq));
  abu_core_model u_core (.sys_clk_i(clk), .rstn_i(rstn), .fetch_addr_i(fa), .fetch_pc_i(fpc),
    .in_break_i(inb), .cpu_addr_o(ca), .cpu_addr_from_pc_o(pc), .cpu_rti_o(return_from_interrupt));
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return awr && wr_;
      1: return bv;
      2: return arr;
      3: return rv;
      4: return inb;
      default: return !inb;
    endcase
  endfunction
  // Bounded wait; a hang ends the run as a mismatch
  task waitfor(input int w);
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (sel(w)) return;
    end
    fail_count++;
    close_out();
  endtask
  // Bus masters hold valid and payload until the handshake edge
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'h1;
    wv <= 1'h1;
    waitfor(0);
    awv <= 1'h0;
    wv <= 1'h0;
    waitfor(1);
    resp = bresp;
  endtask
  task rd(input logic [15:0] a);
    ara <= a;
    arv <= 1'h1;
    waitfor(2);
    arv <= 1'h0;
    waitfor(3);
    q = rdat;
    resp = rresp;
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rstn, awv, wv, arv, stop, fpc, wm} = 7'h00;
    {awa, ara, wd, ws} = '0;
    hv = 1'h1;
    fa = 16'h1234;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    rd(16'hfe0c);
    chk("word", q, 32'h0000_0000);
    wr(16'hfe0c, 32'h0080_3412, 4'h7);
    rd(16'hfe0c);
    chk("word", q, 32'h0080_3412);
    // Data access at the break address, then one fetch of it
    repeat (6) @(posedge clk);
    chk("req", req, 1'h0);
    fpc <= 1'h1;
    @(posedge clk);
    fa <= 16'h2000;
    waitfor(4);
    chk("timer", tst, 1'h1);
    chk("wdog", wdd, 1'h1);
    chk("clr", fca, 1'h0);
    rd(16'hfe0c);
    chk("word", q, 32'h00c0_3412);
    wr(16'hfe10, 32'h0000_0080, 4'h1);
    chk("clr", fca, 1'h1);
    wr(16'hfe0c, 32'h0080_0000, 4'h4);
    waitfor(5);
    rd(16'hfe0c);
    chk("word", q, 32'h0080_3412);
    // Match path off: fetch of the address is ignored
    wr(16'hfe0c, 32'h0000_0000, 4'h4);
    fa <= 16'h1234;
    repeat (6) @(posedge clk);
    chk("req", req, 1'h0);
    fa <= 16'h2000;
    // Software break with only its event unmasked
    wr(16'hfe18, 32'h0000_0002, 4'h1);
    chk("irq", irq, 1'h0);
    wr(16'hfe0c, 32'h0040_0000, 4'h4);
    waitfor(4);
    chk("irq", irq, 1'h1);
    rd(16'hfe14);
    chk("ists", q, 32'h0000_0003);
    wr(16'hfe14, 32'h0000_0003, 4'h1);
    chk("irq", irq, 1'h0);
    wr(16'hfe0c, 32'h0000_0000, 4'h4);
    waitfor(5);
    // Software break while waiting; the core leaves wait once the break is entered
    wm <= 1'h1;
    wr(16'hfe0c, 32'h0040_0000, 4'h4);
    waitfor(4);
    rd(16'hfe1c);
    chk("sys", q, 32'h0000_0003);
    rd(16'hfe14);
    chk("ists", q, 32'h0000_0006);
    wr(16'hfe14, 32'h0000_0006, 4'h1);
    wr(16'hfe0c, 32'h0000_0000, 4'h4);
    wm <= 1'h0;
    waitfor(5);
    // Stop mode: no request, registers kept
    stop <= 1'h1;
    wr(16'hfe0c, 32'h0040_0000, 4'h4);
    repeat (4) @(posedge clk);
    chk("req", req, 1'h0);
    wr(16'hfe0c, 32'h0000_0000, 4'h4);
    stop <= 1'h0;
    rd(16'hfe0c);
    chk("word", q, 32'h0000_3412);
    rd(16'hf000);
    chk("resp", resp, 2'h2);
    close_out();
  end
endmodule
`default_nettype wire
